/* File: src/slx_pkg.sv */
// Purpose: Shared constants for the power-down and literal-subtract execution block
// Assumes: 8-bit data path, 14-bit instruction word, four phases per instruction cycle
// Notes: Phase order is fixed as 1, 2, 3, 4
package slx_pkg;
  localparam int DATA_W = 8;
  localparam int INSTR_W = 14;
  localparam int WDT_W = 8;
  localparam int PRE_W = 8;
  // Opcodes
  localparam logic [13:0] OP_SLEEP = 14'h0063;
  localparam logic [4:0] OP_SUBL_HI = 5'h1e;
  localparam int SUBL_HI_POS = 9;
  // Reset values
  localparam logic [7:0] W_RST = 8'h00;
  localparam logic [7:0] WDT_CLR = 8'h00;
  localparam logic [7:0] PRE_CLR = 8'h00;
  localparam logic TO_RST = 1'b1;
  localparam logic PD_RST = 1'b1;
  // Timing
  localparam int CLK_NS = 100;
  localparam int PHASES = 4;
  localparam int PHASE_CYC = (PHASES * CLK_NS) / CLK_NS;
  typedef enum {PH1, PH2, PH3, PH4} slx_phase_e;
endpackage : slx_pkg

/* File: src/slx_alu_if.sv */
// Purpose: Carries subtract operands and results between core and ALU
// Assumes: Combinational ALU
// Notes: None
`timescale 1ns/1ps
interface slx_alu_if;
  logic [7:0] lit;
  logic [7:0] acc;
  logic [7:0] diff;
  logic carry;
  logic dcarry;
  logic zero;
  modport core (output lit, output acc, input diff, input carry, input dcarry, input zero);
  modport alu (input lit, input acc, output diff, output carry, output dcarry, output zero);
endinterface : slx_alu_if

/* File: src/slx_sub_alu.sv */
// Purpose: Literal minus accumulator with inverted-borrow flags
// Assumes: Operands stable during phase three
// Notes: Carry and digit carry are set when no borrow occurs
`timescale 1ns/1ps
module slx_sub_alu (
  slx_alu_if.alu a
);
  import slx_pkg::*;
  logic [8:0] full;
  logic [4:0] low;
  always_comb begin
    full = {1'b0, a.lit} - {1'b0, a.acc};
    low = {1'b0, a.lit[3:0]} - {1'b0, a.acc[3:0]};
    a.diff = full[7:0];
    a.carry = ~full[8];
    a.dcarry = ~low[4];
    a.zero = (full[7:0] == 8'h00);
  end
endmodule : slx_sub_alu

/* File: src/slx_exec.sv */
// Purpose: Executes the power-down and literal-subtract instructions
// Assumes: Instruction word valid from phase one of its cycle
// Notes: Other instructions are ignored here
// Function
// - Power-down clears watchdog counter and its prescaler to zero.
// - Power-down sets time-out flag, clears power-down flag, nothing else.
// - After power-down, oscillator stops and fetching halts.
// - Power-down: decode phase one, idle two and three, sleep phase four.
// - Literal subtract computes literal minus accumulator, instruction bit eight ignored.
// - The difference replaces the accumulator contents.
// - Subtract: decode, read literal, compute, write accumulator in phase four.
// - Positive result, no borrow, sets carry.
// - Zero result sets zero flag and carry.
// - Negative result, borrow, clears carry.
`timescale 1ns/1ps
module slx_exec (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  // Instruction
  input wire logic [slx_pkg::INSTR_W-1:0] instr,
  // Wake request
  input wire logic wake,
  // State
  output logic [slx_pkg::DATA_W-1:0] accum,
  output logic carry_flag,
  output logic digit_carry_flag,
  output logic zero_flag,
  output logic timeout_flag_n,
  output logic powerdown_flag_n,
  output logic [slx_pkg::WDT_W-1:0] watchdog_counter,
  output logic [slx_pkg::PRE_W-1:0] wdt_prescaler,
  output logic osc_run,
  output logic fetch_en,
  output logic [1:0] phase
);
  import slx_pkg::*;

  // ---------------------------------------------
  // Phase sequencer
  // ---------------------------------------------
  slx_phase_e ph_r;
  logic sleep_r;
  logic is_sleep_r;
  logic is_sub_r;
  logic [7:0] lit_r;
  logic [7:0] diff_r;
  logic c_r;
  logic dc_r;
  logic z_r;
  slx_alu_if alu_bus ();

  // ---------------------------------------------
  // Elaboration checks
  // ---------------------------------------------
  if (DATA_W != 8) begin : g_bad_data
    $error("slx_exec: data width must be 8");
  end
  if (INSTR_W != 14) begin : g_bad_instr
    $error("slx_exec: instruction width must be 14");
  end
  if (WDT_W != 8) begin : g_bad_wdt
    $error("slx_exec: watchdog width must be 8");
  end
  if (PRE_W != 8) begin : g_bad_pre
    $error("slx_exec: prescaler width must be 8");
  end
  if (PHASES != 4) begin : g_bad_phases
    $error("slx_exec: four phases per cycle expected");
  end
  if (SUBL_HI_POS + 5 != INSTR_W) begin : g_bad_opfield
    $error("slx_exec: subtract opcode field must reach the top bit");
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ph_r <= PH1;
    end else if (clk_en && !sleep_r) begin
      case (ph_r)
        PH1: ph_r <= PH2;
        PH2: ph_r <= PH3;
        PH3: ph_r <= PH4;
        PH4: ph_r <= PH1;
        default: ph_r <= PH1;
      endcase
    end
  end

  // ---------------------------------------------
  // Decode
  // ---------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      is_sleep_r <= 1'b0;
      is_sub_r <= 1'b0;
    end else if (clk_en && !sleep_r && ph_r == PH1) begin
      is_sleep_r <= (instr == OP_SLEEP);
      is_sub_r <= (instr[13:SUBL_HI_POS] == OP_SUBL_HI);
    end
  end

  // ---------------------------------------------
  // Literal capture
  // ---------------------------------------------
  // read literal in phase two
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      lit_r <= 8'h00;
    end else if (clk_en && !sleep_r && ph_r == PH2 && is_sub_r) begin
      lit_r <= instr[7:0];
    end
  end

  // ---------------------------------------------
  // Arithmetic
  // ---------------------------------------------
  assign alu_bus.lit = lit_r;
  assign alu_bus.acc = accum;
  slx_sub_alu u_alu (
    .a(alu_bus)
  );

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      diff_r <= 8'h00;
      c_r <= 1'b0;
      dc_r <= 1'b0;
      z_r <= 1'b0;
    end else if (clk_en && !sleep_r && ph_r == PH3 && is_sub_r) begin
      diff_r <= alu_bus.diff;
      c_r <= alu_bus.carry;
      dc_r <= alu_bus.dcarry;
      z_r <= alu_bus.zero;
    end
  end

  // ---------------------------------------------
  // Write-back
  // ---------------------------------------------
  // write accumulator in phase four
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      accum <= W_RST;
    end else if (clk_en && !sleep_r && ph_r == PH4 && is_sub_r) begin
      accum <= diff_r;
    end
  end

  // ---------------------------------------------
  // Arithmetic flags
  // ---------------------------------------------
  // status flags with the write
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      carry_flag <= 1'b0;
      digit_carry_flag <= 1'b0;
      zero_flag <= 1'b0;
    end else if (clk_en && !sleep_r && ph_r == PH4 && is_sub_r) begin
      carry_flag <= c_r;
      digit_carry_flag <= dc_r;
      zero_flag <= z_r;
    end
  end

  // ---------------------------------------------
  // Power-down
  // ---------------------------------------------
  logic go_sleep;
  assign go_sleep = clk_en && !sleep_r && ph_r == PH4 && is_sleep_r;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      watchdog_counter <= WDT_CLR;
      wdt_prescaler <= PRE_CLR;
    end else if (go_sleep) begin
      watchdog_counter <= WDT_CLR;
      wdt_prescaler <= PRE_CLR;
    end
  end

  // ---------------------------------------------
  // Status bits
  // ---------------------------------------------
  // time-out set, power-down cleared
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      timeout_flag_n <= TO_RST;
      powerdown_flag_n <= PD_RST;
    end else if (go_sleep) begin
      timeout_flag_n <= 1'b1;
      powerdown_flag_n <= 1'b0;
    end
  end

  // ---------------------------------------------
  // Sleep control
  // ---------------------------------------------
  // stop oscillator until wake
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      sleep_r <= 1'b0;
    end else if (clk_en) begin
      if (go_sleep) begin
        sleep_r <= 1'b1;
      end else if (sleep_r && wake) begin
        sleep_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------
  // Outputs
  // ---------------------------------------------
  assign osc_run = ~sleep_r;
  assign fetch_en = ~sleep_r;
  assign phase = 2'(ph_r);
endmodule : slx_exec

/* File: tb/slx_exec_monitor.sv */
// Purpose: Port checks for subtract and power-down
// Assumes: Phase 0 decodes
// Notes: Bound to slx_exec
`timescale 1ns/1ps
module slx_exec_monitor import slx_pkg::*; (
  input wire logic clk_sys, rst_b, clk_en, wake, osc_run, fetch_en,
  input wire logic carry_flag, digit_carry_flag, zero_flag, timeout_flag_n, powerdown_flag_n,
  input wire logic [13:0] instr,
  input wire logic [7:0] accum, watchdog_counter, wdt_prescaler,
  input wire logic [1:0] phase
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  wire go = phase == 2'h0 && clk_en && osc_run;
  wire sub_go = go && instr[13:9] == OP_SUBL_HI;
  wire slp_go = go && instr == OP_SLEEP;
  phase_step_a: assert property (clk_en && osc_run && phase != 2'h3 |=> phase == $past(phase) + 2'h1)
    else $error("phase stuck");
  acc_write_a: assert property ($changed(accum) |-> $past(phase) == 2'h3)
    else $error("accum early");
  sub_diff_a: assert property (sub_go |=> ##3 accum == $past(instr[7:0], 4) - $past(accum, 4))
    else $error("bad diff");
  sub_carry_a: assert property (sub_go |=> ##3 carry_flag == ($past(instr[7:0], 4) >= $past(accum, 4)))
    else $error("bad carry");
  sub_zero_a: assert property (sub_go |=> ##3 zero_flag == (accum == 8'h00))
    else $error("bad zero");
  sub_dc_a: assert property (sub_go |=> ##3 digit_carry_flag == ($past(instr[3:0], 4) >= $past(accum[3:0], 4)))
    else $error("bad digit carry");
  wdt_clear_a: assert property (slp_go |=> ##3 !(|watchdog_counter) && !(|wdt_prescaler) && !osc_run)
    else $error("no clear");
  stat_flags_a: assert property (slp_go |=> ##3 timeout_flag_n && !powerdown_flag_n && $stable(carry_flag))
    else $error("bad status");
  osc_stop_a: assert property ($fell(osc_run) |-> $past(phase) == 2'h3 && !fetch_en)
    else $error("stop early");
  sleep_hold_a: assert property (!osc_run && !wake |=> $stable(phase) && !fetch_en)
    else $error("ran asleep");
  cover property (sub_go);
  cover property (slp_go);
  cover property ($rose(osc_run));
endmodule : slx_exec_monitor
bind slx_exec slx_exec_monitor i_slx_exec_monitor (.*);

/* File: tb/tb_slx_exec.sv */
// Purpose: Runs subtract and power-down sequences
// Assumes: One instruction per four cycles
// Notes: Inputs change on the falling edge
`timescale 1ns/1ps
module tb_slx_exec;
  import slx_pkg::*;
  logic clk_sys = 0, rst_b = 0, clk_en = 1, wake = 0;
  logic [13:0] instr = 14'h0000;
  logic [7:0] accum, wdt, pre, a, k, d;
  logic c, dc, z, to_n, pd_n, osc, fen;
  logic [1:0] phase;
  int err_total = 0, comparisons = 0;
  always #50 clk_sys = ~clk_sys;
  slx_exec i_slx_exec (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en), .instr(instr), .wake(wake),
    .accum(accum), .carry_flag(c), .digit_carry_flag(dc), .zero_flag(z), .timeout_flag_n(to_n),
    .powerdown_flag_n(pd_n), .watchdog_counter(wdt), .wdt_prescaler(pre), .osc_run(osc),
    .fetch_en(fen), .phase(phase));
  task chk(input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task run(input logic [13:0] op);
    instr = op;
    repeat (4) @(negedge clk_sys);
  endtask : run
  task sub(input logic [7:0] lit, input logic xb);
    a = accum;
    k = lit;
    run({OP_SUBL_HI, xb, lit});
    d = k - a;
    chk(accum, d);
    chk(c, k >= a);
    chk(z, d == 8'h00);
    chk(dc, k[3:0] >= a[3:0]);
    chk(phase, 8'h00);
  endtask : sub
  task summarize;
    $display("Comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  initial begin
    #20000;
    err_total++;
    summarize;
  end
  initial begin
    repeat (2) @(negedge clk_sys);
    rst_b = 1;
    sub(8'h02, 0);
    sub(8'h02, 0);
    sub(8'h01, 1);
    sub(8'h00, 0);
    sub(8'h10, 1);
    a = accum;
    clk_en = 0;
    instr = {OP_SUBL_HI, 1'b0, 8'h33};
    repeat (3) @(negedge clk_sys);
    chk(phase, 8'h00);
    chk(accum, a);
    clk_en = 1;
    sub(8'h33, 0);
    $display("Subtract test done");
    a = {5'h00, c, dc, z};
    run(OP_SLEEP);
    chk({to_n, pd_n, osc, fen}, 8'h08);
    chk(wdt | pre, 8'h00);
    chk({c, dc, z}, a);
    repeat (3) @(negedge clk_sys);
    chk(phase, 8'h00);
    wake = 1;
    @(negedge clk_sys);
    wake = 0;
    chk({osc, phase}, 8'h04);
    sub(8'h05, 0);
    $display("Sleep test done");
    summarize;
  end
endmodule : tb_slx_exec
